/* File: dpr_pkg.sv */
// Purpose: Shared constants for the DMA-protected region register block
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes:   High base occupies two words (low word at 0x70, high at 0x74)
package dpr_pkg;
    // Register byte offsets
    localparam logic [7:0] LOW_REGION_LIMIT_OFF = 8'h6c;
    localparam logic [7:0] HIGH_BASE_LO_OFF     = 8'h70;
    localparam logic [7:0] HIGH_BASE_HI_OFF     = 8'h74;
    // Reset values
    localparam logic [31:0] LOW_LIMIT_RST = 32'h0000_0000;
    localparam logic [63:0] HIGH_BASE_RST = 64'h0000_0000_0000_0000;
    // Default alignment and address width
    localparam int ALIGN_N_DEF   = 11;
    localparam int HOST_AW_DEF   = 39;
    // Low region lies below this boundary
    localparam logic [63:0] LOW_REGION_CEIL = 64'h0000_0001_0000_0000;
endpackage

/* File: dpr_region_check.sv */
// Purpose: Range compare of one DMA address against one protected region
// Assumes: Base and limit already decoded to full byte addresses
// Notes:   Purely combinational; the parent registers the result
`timescale 1ns/10ps
module dpr_region_check #(
    parameter int AW = 64
) (
    input  wire logic [AW-1:0] base,
    input  wire logic [AW-1:0] limit,
    input  wire logic [AW-1:0] addr,
    output logic               valid,
    output logic               hit
);
    // Region valid only when limit is not below base
    assign valid = (limit >= base);
    // Inclusive range hit
    assign hit   = valid && (addr >= base) && (addr <= limit);
endmodule // dpr_region_check

/* File: dpr_regs.sv */
// Purpose: Low-region limit and high-region base registers with decode and DMA range flag
// Assumes: Low-region base and high-region limit come from neighbouring logic
// Notes:   Bits N:0 of both registers are hardwired zero
`timescale 1ns/10ps
module dpr_regs #(
    parameter int ALIGN_N = dpr_pkg::ALIGN_N_DEF,
    parameter int HOST_AW = dpr_pkg::HOST_AW_DEF
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        low_region_supported,
    input  wire logic        high_region_supported,
    input  wire logic        protected_region_status,
    input  wire logic [31:0] low_region_base,
    input  wire logic [63:0] high_region_limit,
    input  wire logic [63:0] dma_addr,
    output logic [31:0]      low_base_dec,
    output logic [31:0]      low_limit_dec,
    output logic [63:0]      high_base_dec,
    output logic [63:0]      high_limit_dec,
    output logic             low_region_valid,
    output logic             high_region_valid,
    output logic             dma_protected
);

    ////////////////////////////////////////////////////////////////////////
    // Field masks
    ////////////////////////////////////////////////////////////////////////
    localparam logic [31:0] LOW_MASK = ~((32'h0000_0002 << ALIGN_N) - 32'h0000_0001);
    localparam logic [63:0] AW_MASK  = (64'h0000_0000_0000_0001 << HOST_AW)
                                       - 64'h0000_0000_0000_0001;
    localparam logic [63:0] HI_MASK  = AW_MASK &
        ~((64'h0000_0000_0000_0002 << ALIGN_N) - 64'h0000_0000_0000_0001);

    logic [31:0] low_limit_q;
    logic [63:0] high_base_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    ////////////////////////////////////////////////////////////////////////
    wire sel_low  = (reg_addr == dpr_pkg::LOW_REGION_LIMIT_OFF);
    wire sel_hlo  = (reg_addr == dpr_pkg::HIGH_BASE_LO_OFF);
    wire sel_hhi  = (reg_addr == dpr_pkg::HIGH_BASE_HI_OFF);
    wire wr_low   = reg_wr && sel_low && low_region_supported;
    wire wr_hlo   = reg_wr && sel_hlo && high_region_supported;
    wire wr_hhi   = reg_wr && sel_hhi && high_region_supported;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    ////////////////////////////////////////////////////////////////////////
    // low limit storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_limit_q <= dpr_pkg::LOW_LIMIT_RST;
        end else if (wr_low) begin
            low_limit_q <= reg_wdata & LOW_MASK;
        end
    end

    // Either half of the high base selects a 64-bit merge
    wire        wr_lo_or_hi = wr_hlo || wr_hhi;
    wire [63:0] high_base_d = wr_hlo ? {high_base_q[63:32], reg_wdata}
                                     : {reg_wdata, high_base_q[31:0]};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            high_base_q <= dpr_pkg::HIGH_BASE_RST;
        end else if (wr_lo_or_hi) begin
            high_base_q <= high_base_d & HI_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, data one cycle after strobe
    ////////////////////////////////////////////////////////////////////////
    assign rdata_d = !reg_rd ? 32'h0000_0000 :
                     sel_low ? low_limit_q :
                     sel_hlo ? high_base_q[31:0] :
                     sel_hhi ? high_base_q[63:32] : 32'h0000_0000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode of region bounds
    ////////////////////////////////////////////////////////////////////////
    // limit low bits ones
    wire [31:0] low_lim_w  = low_limit_q | ~LOW_MASK;
    wire [31:0] low_base_w = low_region_base & LOW_MASK;
    wire [63:0] hi_base_w  = high_base_q & HI_MASK;
    wire [63:0] hi_lim_w   = high_region_limit | ~HI_MASK;

    logic lo_valid_w;
    logic hi_valid_w;
    logic lo_hit_w;
    logic hi_hit_w;

    dpr_region_check #(.AW(64)) u_low (
        .base  ({32'h0000_0000, low_base_w}),
        .limit ({32'h0000_0000, low_lim_w}),
        .addr  (dma_addr),
        .valid (lo_valid_w),
        .hit   (lo_hit_w)
    );

    dpr_region_check #(.AW(64)) u_high (
        .base  (hi_base_w),
        .limit (hi_lim_w),
        .addr  (dma_addr),
        .valid (hi_valid_w),
        .hit   (hi_hit_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    ////////////////////////////////////////////////////////////////////////
    // flag gated by status
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_base_dec      <= 32'h0000_0000;
            low_limit_dec     <= 32'h0000_0000;
            high_base_dec     <= 64'h0000_0000_0000_0000;
            high_limit_dec    <= 64'h0000_0000_0000_0000;
            low_region_valid  <= 1'b0;
            high_region_valid <= 1'b0;
            dma_protected     <= 1'b0;
        end else begin
            low_base_dec      <= low_base_w;
            low_limit_dec     <= low_lim_w;
            high_base_dec     <= hi_base_w;
            high_limit_dec    <= hi_lim_w;
            low_region_valid  <= lo_valid_w;
            high_region_valid <= hi_valid_w;
            dma_protected     <= protected_region_status && (lo_hit_w || hi_hit_w);
        end
    end

endmodule // dpr_regs

/* File: dpr_regs_monitor.sv */
// Purpose: Concurrent checks on the protected region register ports
// Assumes: Decoded outputs lag their sources by one cycle
// Notes:   Bound to every dpr_regs instance
`timescale 1ns/10ps
module dpr_regs_monitor #(
    parameter int ALIGN_N = 11,
    parameter int HOST_AW = 39
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        low_region_supported,
    input wire logic        protected_region_status,
    input wire logic [63:0] dma_addr,
    input wire logic [31:0] low_base_dec,
    input wire logic [31:0] low_limit_dec,
    input wire logic [63:0] high_base_dec,
    input wire logic        low_region_valid,
    input wire logic        dma_protected
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Address inside an enabled, valid low region
    sequence s_low_hit;
        protected_region_status && low_region_valid && dma_addr[63:32] == 0 &&
        dma_addr[31:0] >= low_base_dec && dma_addr[31:0] <= low_limit_dec;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data outside read slot");
    a_rd_lowbits: assert property (reg_rd && reg_addr != 8'h74 |=> reg_rdata[ALIGN_N:0] == 0)
        else $error("low bits read nonzero");
    a_ro_low: assert property (reg_wr && reg_addr == 8'h6c && !low_region_supported |=> $stable(low_limit_dec)[*2])
        else $error("limit changed while read-only");
    a_limit_ones: assert property ($past(rstn) |-> &low_limit_dec[ALIGN_N:0])
        else $error("limit low bits not ones");
    a_base_zeros: assert property (high_base_dec[ALIGN_N:0] == 0 && low_base_dec[ALIGN_N:0] == 0)
        else $error("base low bits not zero");
    a_haw_zero: assert property (high_base_dec[63:HOST_AW] == 0)
        else $error("base bits above width set");
    a_low_valid: assert property ($past(rstn) |-> low_region_valid == (low_limit_dec >= low_base_dec))
        else $error("low valid wrong");
    a_prot_off: assert property (!protected_region_status |=> !dma_protected)
        else $error("flag while disabled");
    a_prot_hit: assert property (s_low_hit |=> dma_protected)
        else $error("hit not flagged");
endmodule // dpr_regs_monitor
bind dpr_regs dpr_regs_monitor #(.ALIGN_N(ALIGN_N), .HOST_AW(HOST_AW)) u_dpr_regs_monitor (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_region_supported(low_region_supported),
    .protected_region_status(protected_region_status), .dma_addr(dma_addr),
    .low_base_dec(low_base_dec), .low_limit_dec(low_limit_dec), .high_base_dec(high_base_dec),
    .low_region_valid(low_region_valid), .dma_protected(dma_protected));

/* File: dpr_regs_bench.sv */
// Purpose: Self-checking bench for the protected region registers
// Assumes: Default alignment 11 and address width 39
// Notes:   Reads are queued and compared when the data slot arrives
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module dpr_regs_bench;
    logic        clk = 0, rstn = 0, wr_s = 0, rd_s = 0, lsup = 1, hsup = 1, stat = 0, rd_seen = 0;
    logic [7:0]  addr = 0;
    logic [31:0] wdata = 0, lbase = 0, rdata, lbd, lld, d, ev;
    logic [63:0] dma = 0, hbd;
    logic        lval, prot;
    logic [31:0] exp_q[$];
    int          seed = 3486, mismatches = 0, total_checks = 0, cycles = 0;
    always #20 clk = ~clk;
    dpr_regs u_dpr_regs (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .low_region_supported(lsup),
        .high_region_supported(hsup), .protected_region_status(stat), .low_region_base(lbase),
        .high_region_limit(64'h0000_0000_0000_0000), .dma_addr(dma), .low_base_dec(lbd),
        .low_limit_dec(lld), .high_base_dec(hbd), .high_limit_dec(), .low_region_valid(lval),
        .high_region_valid(), .dma_protected(prot));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        addr  <= a;
        wdata <= v;
        wr_s  <= 1;
        @(posedge clk);
        wr_s  <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd_s <= 1;
        @(posedge clk);
        rd_s <= 0;
        @(posedge clk);
    endtask
    // Read data watcher and hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            mismatches++;
            end_of_test();
        end
        if (rd_seen) begin
            ev = exp_q.pop_front();
            `CHK("rdata", ev, rdata)
        end
        rd_seen <= rd_s;
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        wr(8'h80, 32'hffff_ffff);
        rd(8'h80, 32'h0000_0000);
        rd(8'h6c, 32'h0000_0000);
        rd(8'h74, 32'h0000_0000);
        `CHK("lld", 32'h0000_0fff, lld)
        @(posedge clk);
        $display("reset values done");
        wr(8'h6c, 32'hffff_ffff);
        wr(8'h70, 32'hffff_ffff);
        wr(8'h74, 32'hffff_ffff);
        rd(8'h6c, 32'hffff_f000);
        rd(8'h70, 32'hffff_f000);
        rd(8'h74, 32'h0000_007f);
        `CHK("hbd", 64'h0000_007f_ffff_f000, hbd)
        @(posedge clk);
        lsup <= 0;
        hsup <= 0;
        @(posedge clk);
        wr(8'h6c, 32'h0000_0000);
        wr(8'h70, 32'h0000_0000);
        rd(8'h6c, 32'hffff_f000);
        rd(8'h70, 32'hffff_f000);
        lsup <= 1;
        hsup <= 1;
        $display("read-only done");
        repeat (4) begin
            d = $random(seed);
            wr(8'h6c, d);
            rd(8'h6c, d & 32'hffff_f000);
        end
        lbase <= 32'h1000_0000;
        wr(8'h6c, 32'h1000_0000);
        stat <= 1;
        dma  <= 64'h0000_0000_1000_0fff;
        repeat (3) @(posedge clk);
        `CHK("lval", 1'b1, lval)
        `CHK("prot", 1'b1, prot)
        dma <= 64'h0000_0000_1000_1000;
        repeat (2) @(posedge clk);
        `CHK("prot", 1'b0, prot)
        stat <= 0;
        dma  <= 64'h0000_0000_1000_0000;
        repeat (2) @(posedge clk);
        `CHK("prot", 1'b0, prot)
        lbase <= 32'h2000_0000;
        repeat (2) @(posedge clk);
        stat <= 1;
        repeat (3) @(posedge clk);
        `CHK("lval", 1'b0, lval)
        `CHK("prot", 1'b0, prot)
        $display("region tests done");
        end_of_test();
    end
endmodule // dpr_regs_bench
